// ===== test/omd_cpu_model.sv
// CPU core model issuing byte and word accesses
module omd_cpu_model (
  // Clock
  input wire logic ref_clk_in,
  // Decoder handshake
  input wire logic req_ready_in,
  input wire logic route_valid_in,
  output logic req_valid_out,
  output omd_pkg::omd_req_t req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_valid_out = 1'h0;
    req_out = '0;
  end
  // Plain accesses only, none into reserved flash
  task automatic send(input logic [23:0] a, input logic w, input int gap, output int n);
    int k;
    repeat (gap) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    req_valid_out <= 1'h1;
    req_out <= '{addr: a, is_word: w, is_write: !w};
    k = 0;
    do begin
      @(posedge ref_clk_in);
      k++;
    end while (req_ready_in !== 1'h1 && k < 20);
    req_valid_out <= 1'h0;
    req_out <= ~req_out;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (route_valid_in !== 1'h1 && n < 20);
  endtask
endmodule

// ===== test/omd_decoder_props.sv
// Concurrent checks on the memory map decoder ports
module omd_decoder_props (
  // Clock, reset, mode
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic bootstrap_mode_in,
  // Configuration
  input wire logic global_xbus_periph_enable_in,
  input wire logic [15:0] xbus_periph_config_reg_in,
  input wire logic xbus_window3_wr_in,
  input wire logic [7:0] xbus_window3_seg_in,
  // Request and route
  input wire logic req_valid_in,
  input wire omd_pkg::omd_req_t req_in,
  input wire logic req_ready_out,
  input wire logic route_valid_out,
  input wire omd_pkg::omd_route_t route_out,
  // Status
  input wire logic [7:0] xbus_window3_seg_out,
  input wire logic [15:0] periph_visible_out,
  input wire logic [3:0] seg_lines_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  logic take;
  logic periph;
  logic xram;
  logic [23:0] addr_ff;
  logic word_ff;
  logic boot_ff;
  omd_pkg::omd_target_t tgt;
  assign take = req_valid_in && req_ready_out;
  assign tgt = route_out.target;
  assign periph = tgt >= omd_pkg::TGT_CAN1 && tgt <= omd_pkg::TGT_MISC;
  assign xram = tgt == omd_pkg::TGT_XRAM_LO || tgt == omd_pkg::TGT_XRAM_HI;
  ////////////////////////////////////////////////////////////
  // Request captured at take
  always_ff @(posedge ref_clk_in) begin
    if (take) begin
      addr_ff <= req_in.addr;
      word_ff <= req_in.is_word;
      boot_ff <= bootstrap_mode_in;
    end
  end
  sequence s_ans;
    route_valid_out;
  endsequence
  ////////////////////////////////////////////////////////////
  a_flash_map: assert property (s_ans ##0 tgt == omd_pkg::TGT_FLASH |->
    !(boot_ff && addr_ff < 24'h002000) &&
    (addr_ff < 24'h008000 || (addr_ff >= 24'h018000 && addr_ff <= 24'h04FFFF)))
    else $error("flash route outside flash map");
  a_test_flash: assert property (s_ans ##0 tgt == omd_pkg::TGT_TEST_FLASH |->
    boot_ff && addr_ff < 24'h002000)
    else $error("test flash routed outside bootstrap");
  a_xram_zero: assert property (s_ans ##0 xram |->
    $past(take) && route_out.waits == 2'h0 && !route_out.size_error)
    else $error("extension ram access not zero wait");
  a_xram_low_map: assert property (s_ans ##0 tgt == omd_pkg::TGT_XRAM_LO |->
    addr_ff >= 24'h00E000 && addr_ff <= 24'h00E7FF && periph_visible_out[2])
    else $error("low extension ram decoded wrongly");
  a_window_load: assert property (xbus_window3_wr_in |=>
    xbus_window3_seg_out == $past(xbus_window3_seg_in))
    else $error("window segment not loaded");
  a_periph_waits: assert property (s_ans ##0 periph |->
    $past(take, 3) && route_out.waits == 2'h2 && route_out.word_only)
    else $error("peripheral access not two wait word only");
  a_byte_refused: assert property (s_ans ##0 periph |-> route_out.size_error == !word_ff)
    else $error("peripheral size error wrong");
  a_can_seg_lines: assert property (seg_lines_out ==
    ((periph_visible_out[0] || periph_visible_out[1]) ? 4'h4 : 4'h8))
    else $error("segment line count wrong");
  a_global_clears: assert property (!global_xbus_periph_enable_in |=>
    periph_visible_out == 16'h0000)
    else $error("peripherals visible with global enable low");
endmodule

bind omd_decoder omd_decoder_props omd_decoder_props_i (.*);

// ===== test/onchip_memory_map_decoder_tb_top.sv
// Self-checking bench for the memory map decoder
module onchip_memory_map_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [23:0] addr;
    logic word;
    logic boot;
    omd_pkg::omd_target_t tgt;
    logic [1:0] waits;
  } omd_row_t;
  logic ref_clk_in;
  logic nrst_in;
  logic boot;
  logic glob;
  logic [15:0] cfg;
  logic win_wr;
  logic [7:0] win_seg;
  logic req_valid;
  omd_pkg::omd_req_t req;
  logic ready;
  logic rv;
  omd_pkg::omd_route_t route;
  logic [7:0] seg;
  logic [15:0] vis;
  logic [3:0] lines;
  int failures;
  int samples_checked;
  int cycles;
  int lat;
  omd_row_t rows[17];
  omd_decoder omd_decoder_i (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .bootstrap_mode_in(boot),
    .global_xbus_periph_enable_in(glob), .xbus_periph_config_reg_in(cfg),
    .xbus_window3_wr_in(win_wr), .xbus_window3_seg_in(win_seg),
    .req_valid_in(req_valid), .req_in(req), .req_ready_out(ready),
    .route_valid_out(rv), .route_out(route), .xbus_window3_seg_out(seg),
    .periph_visible_out(vis), .seg_lines_out(lines));
  omd_cpu_model omd_cpu_model_i (
    .ref_clk_in(ref_clk_in), .req_ready_in(ready), .route_valid_in(rv),
    .req_valid_out(req_valid), .req_out(req));
  always #25 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      results();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task go(input logic [23:0] a, input logic w, input omd_pkg::omd_target_t t,
          input logic [1:0] wt);
    omd_cpu_model_i.send(a, w, 0, lat);
    check(route.target, t);
    check(lat, wt + 2'h1);
    check(route.size_error, wt != 2'h0 && !w);
    check(route.waits, wt);
    check(route.word_only, wt != 2'h0);
  endtask
  task set_en(input logic [15:0] c);
    @(posedge ref_clk_in);
    glob <= 1'h0;
    @(posedge ref_clk_in);
    cfg <= c;
    glob <= 1'h1;
    repeat (3) @(posedge ref_clk_in);
  endtask
  initial begin
    ref_clk_in = 1'h0;
    nrst_in = 1'h0;
    boot = 1'h0;
    glob = 1'h0;
    cfg = 16'h0000;
    win_wr = 1'h0;
    win_seg = 8'h09;
    rows = '{'{24'h000000, 1'h1, 1'h0, omd_pkg::TGT_FLASH, 2'h0},
      '{24'h000000, 1'h1, 1'h1, omd_pkg::TGT_TEST_FLASH, 2'h0},
      '{24'h007FFF, 1'h0, 1'h0, omd_pkg::TGT_FLASH, 2'h0},
      '{24'h018000, 1'h1, 1'h1, omd_pkg::TGT_FLASH, 2'h0},
      '{24'h02FFFF, 1'h0, 1'h0, omd_pkg::TGT_FLASH, 2'h0},
      '{24'h010000, 1'h1, 1'h0, omd_pkg::TGT_EXTERNAL, 2'h0},
      '{24'h00E000, 1'h0, 1'h0, omd_pkg::TGT_XRAM_LO, 2'h0},
      '{24'h090000, 1'h1, 1'h0, omd_pkg::TGT_XRAM_HI, 2'h0},
      '{24'h094000, 1'h0, 1'h0, omd_pkg::TGT_XRAM_HI, 2'h0},
      '{24'h00EF00, 1'h1, 1'h0, omd_pkg::TGT_CAN1, 2'h2},
      '{24'h00EEFF, 1'h1, 1'h0, omd_pkg::TGT_CAN2, 2'h2},
      '{24'h00ED00, 1'h1, 1'h0, omd_pkg::TGT_RTC, 2'h2},
      '{24'h00ECFE, 1'h0, 1'h0, omd_pkg::TGT_PWM, 2'h2},
      '{24'h00E900, 1'h0, 1'h0, omd_pkg::TGT_ASC, 2'h2},
      '{24'h00E8FF, 1'h1, 1'h0, omd_pkg::TGT_SSC, 2'h2},
      '{24'h00EA00, 1'h1, 1'h0, omd_pkg::TGT_I2C, 2'h2},
      '{24'h00EBFF, 1'h1, 1'h0, omd_pkg::TGT_MISC, 2'h2}};
    repeat (16) @(posedge ref_clk_in);
    nrst_in <= 1'h1;
    @(negedge ref_clk_in);
    check(seg, 8'h09);
    check(vis, 16'h0000);
    check(lines, 4'h8);
    check(ready, 1'h1);
    check(rv, 1'h0);
    set_en(16'h07DF);
    check(lines, 4'h4);
    foreach (rows[i]) begin
      @(posedge ref_clk_in);
      boot <= rows[i].boot;
      go(rows[i].addr, rows[i].word, rows[i].tgt, rows[i].waits);
    end
    go(24'hFFFFFF, 1'h0, omd_pkg::TGT_EXTERNAL, 2'h0);
    go(24'h00F000, 1'h1, omd_pkg::TGT_EXTENDED_SPECIAL_REGS, 2'h0);
    go(24'h00FFFE, 1'h1, omd_pkg::TGT_SFR, 2'h0);
    go(24'h00F600, 1'h0, omd_pkg::TGT_INTERNAL_DUAL_PORT_RAM, 2'h0);
    @(posedge ref_clk_in);
    boot <= 1'h0;
    set_en(16'h07D8);
    check(lines, 4'h8);
    check(vis, 16'h07D8);
    go(24'h00EF00, 1'h1, omd_pkg::TGT_EXTERNAL, 2'h0);
    go(24'h00EE00, 1'h1, omd_pkg::TGT_EXTERNAL, 2'h0);
    go(24'h00E000, 1'h0, omd_pkg::TGT_EXTERNAL, 2'h0);
    go(24'h00EC00, 1'h1, omd_pkg::TGT_PWM, 2'h2);
    @(posedge ref_clk_in);
    cfg <= 16'h07DF;
    repeat (3) @(posedge ref_clk_in);
    go(24'h00EF00, 1'h1, omd_pkg::TGT_EXTERNAL, 2'h0);
    check(vis, 16'h07D8);
    @(posedge ref_clk_in);
    glob <= 1'h0;
    repeat (2) @(posedge ref_clk_in);
    check(vis, 16'h0000);
    go(24'h090000, 1'h1, omd_pkg::TGT_EXTERNAL, 2'h0);
    go(24'h00EBFF, 1'h1, omd_pkg::TGT_EXTERNAL, 2'h0);
    set_en(16'h07DF);
    omd_cpu_model_i.send(24'h00E7FF, 1'h1, 3, lat);
    check(route.target, omd_pkg::TGT_XRAM_LO);
    @(posedge ref_clk_in);
    win_seg <= 8'h0A;
    win_wr <= 1'h1;
    @(posedge ref_clk_in);
    win_wr <= 1'h0;
    go(24'h0A1234, 1'h0, omd_pkg::TGT_XRAM_HI, 2'h0);
    check(route.addr, 24'h001234);
    go(24'h090000, 1'h1, omd_pkg::TGT_EXTERNAL, 2'h0);
    check(seg, 8'h0A);
    @(posedge ref_clk_in);
    nrst_in <= 1'h0;
    repeat (2) @(posedge ref_clk_in);
    nrst_in <= 1'h1;
    @(negedge ref_clk_in);
    check(seg, 8'h09);
    check(vis, 16'h0000);
    check(ready, 1'h1);
    results();
  end
endmodule

// ===== verilog/omd_cfg.svh
// Address map constants for the on-chip memory map decoder
// Function
// R1 - User mode decodes six flash blocks: four 8K, one 32K, one 64K.
// R2 - Bootstrap mode shows the 8K test flash at zero; user mode hides it.
// R3 - Software keeps 03'0000h to 04'FFFFh free of code and data.
// R4 - Extension RAM: 16-bit demultiplexed, zero wait, byte and word allowed.
// R5 - Low extension RAM decoded only with global and its own enable set.
// R6 - Disabled low extension RAM range goes to the external interface.
// R7 - High extension RAM sits at the window register range when enabled.
// R8 - After reset high extension RAM sits at 09'0000h, mirrored every 16K; the code masks with 001FFFh, so it mirrors every 8K.
// R9 - Software uses no extension RAM for stack, register banks or bits.
// R10 - First CAN window at 00'EF00h when global and bit 0 set.
// R11 - Second CAN window at 00'EE00h when global and bit 1 set.
// R12 - Real-time clock window at 00'ED00h when global and bit 4 set.
// R13 - Pulse-width window at 00'EC00h with bit 6; word access only.
// R14 - Async serial window at 00'E900h when global and bit 7 set.
// R15 - Sync serial window at 00'E800h when global and bit 8 set.
// R16 - I2C window at 00'EA00h when global and bit 9 set.
// R17 - Miscellaneous window at 00'EB00h when global and bit 10 set.
// R18 - Peripheral access: demultiplexed, 16-bit word only, two waits, no tristate wait.
// R19 - Any CAN in use limits external bus to four segment lines.
// R20 - Peripheral disabled when global enable rises stays invisible.
// R21 - One linear 16 Mbyte space, byte and word everywhere; the code flags byte accesses in the peripheral windows as size errors.
// R22 - Two 512-byte special register areas are reserved.
// R23 - Anything unmatched goes out as an external bus cycle.
`ifndef OMD_CFG_SVH
`define OMD_CFG_SVH

`define OMD_FLASH_LO_END 24'h007FFF
`define OMD_FLASH_B4_BASE 24'h018000
`define OMD_FLASH_B5_END 24'h02FFFF
`define OMD_FLASH_RSV_END 24'h04FFFF
`define OMD_TFLASH_END 24'h001FFF
`define OMD_XRAM_LO_BASE 24'h00E000
`define OMD_XRAM_LO_END 24'h00E7FF
`define OMD_XRAM_HI_SEG_RST 8'h09
`define OMD_XRAM_HI_MASK 24'h001FFF
`define OMD_SSC_PAGE 16'h00E8
`define OMD_ASC_PAGE 16'h00E9
`define OMD_I2C_PAGE 16'h00EA
`define OMD_MISC_PAGE 16'h00EB
`define OMD_PWM_PAGE 16'h00EC
`define OMD_RTC_PAGE 16'h00ED
`define OMD_CAN2_PAGE 16'h00EE
`define OMD_CAN1_PAGE 16'h00EF
`define OMD_EXTENDED_SPECIAL_REGS_BASE 24'h00F000
`define OMD_EXTENDED_SPECIAL_REGS_END 24'h00F1FF
`define OMD_INTERNAL_DUAL_PORT_RAM_BASE 24'h00F600
`define OMD_INTERNAL_DUAL_PORT_RAM_END 24'h00FDFF
`define OMD_SFR_BASE 24'h00FE00
`define OMD_SFR_END 24'h00FFFF
`define OMD_EN_CAN1 0
`define OMD_EN_CAN2 1
`define OMD_EN_XRAM_LO 2
`define OMD_EN_XRAM_HI 3
`define OMD_EN_RTC 4
`define OMD_EN_PWM 6
`define OMD_EN_ASC 7
`define OMD_EN_SSC 8
`define OMD_EN_I2C 9
`define OMD_EN_MISC 10
`define OMD_PERIPH_WAITS 2'h2
`define OMD_SEG_LINES_FULL 4'h8
`define OMD_SEG_LINES_CAN 4'h4

`endif

// ===== verilog/omd_decoder.sv
// Address decoder steering CPU accesses to on-chip and external targets
`include "omd_cfg.svh"

module omd_decoder (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Mode and configuration
  input wire logic bootstrap_mode_in,
  input wire logic global_xbus_periph_enable_in,
  input wire logic [15:0] xbus_periph_config_reg_in,
  // High extension RAM window register write
  input wire logic xbus_window3_wr_in,
  input wire logic [7:0] xbus_window3_seg_in,
  // CPU request
  input wire logic req_valid_in,
  input wire omd_pkg::omd_req_t req_in,
  output logic req_ready_out,
  // Routed access
  output logic route_valid_out,
  output omd_pkg::omd_route_t route_out,
  // Status
  output logic [7:0] xbus_window3_seg_out,
  output logic [15:0] periph_visible_out,
  output logic [3:0] seg_lines_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Types and state

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DONE
  } omd_state_t;

  omd_state_t state_ff;
  omd_state_t nxt_state;
  logic [1:0] wait_cnt_ff;
  logic [1:0] nxt_wait_cnt;
  logic glb_en_d_ff;
  logic [15:0] vis_en_ff;
  logic [15:0] nxt_vis_en;
  logic [7:0] win3_seg_ff;
  omd_pkg::omd_route_t route_ff;
  omd_pkg::omd_route_t nxt_route;
  logic take;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic in_range(
    input logic [23:0] a,
    input logic [23:0] lo,
    input logic [23:0] hi
  );
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_page(
    input logic [23:0] a,
    input logic [15:0] page
  );
    in_page = (a[23:8] == page);
  endfunction

  function automatic logic is_periph(
    input omd_pkg::omd_target_t t
  );
    case (t)
      omd_pkg::TGT_CAN1, omd_pkg::TGT_CAN2, omd_pkg::TGT_RTC,
      omd_pkg::TGT_PWM, omd_pkg::TGT_ASC, omd_pkg::TGT_SSC,
      omd_pkg::TGT_I2C, omd_pkg::TGT_MISC: begin
        is_periph = 1'b1;
      end
      default: begin
        is_periph = 1'b0;
      end
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Peripheral visibility

  // Per-window enables frozen when the global enable rises
  always_comb begin
    nxt_vis_en = vis_en_ff;
    if (!global_xbus_periph_enable_in) begin
      nxt_vis_en = 16'h0000;
    end else if (!glb_en_d_ff) begin
      nxt_vis_en = xbus_periph_config_reg_in; // see R20
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      glb_en_d_ff <= 1'b0;
    end else begin
      glb_en_d_ff <= global_xbus_periph_enable_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      vis_en_ff <= 16'h0000;
    end else begin
      vis_en_ff <= nxt_vis_en;
    end
  end

  assign periph_visible_out = vis_en_ff;

  // Fewer segment lines while a CAN window is live
  always_comb begin
    if (vis_en_ff[`OMD_EN_CAN1] || vis_en_ff[`OMD_EN_CAN2]) begin
      seg_lines_out = `OMD_SEG_LINES_CAN; // see R19
    end else begin
      seg_lines_out = `OMD_SEG_LINES_FULL;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // High extension RAM window

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      win3_seg_ff <= `OMD_XRAM_HI_SEG_RST; // see R8
    end else if (xbus_window3_wr_in) begin
      win3_seg_ff <= xbus_window3_seg_in; // see R7
    end
  end

  assign xbus_window3_seg_out = win3_seg_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  always_comb begin
    logic [23:0] a;
    a = req_in.addr;
    nxt_route = '0;
    nxt_route.addr = a;
    nxt_route.target = omd_pkg::TGT_EXTERNAL; // see R23
    if (bootstrap_mode_in && in_range(a, 24'h000000, `OMD_TFLASH_END)) begin
      nxt_route.target = omd_pkg::TGT_TEST_FLASH; // see R2
    end else if (in_range(a, 24'h000000, `OMD_FLASH_LO_END)) begin
      nxt_route.target = omd_pkg::TGT_FLASH; // see R1
    end else if (in_range(a, `OMD_FLASH_B4_BASE, `OMD_FLASH_B5_END)) begin
      nxt_route.target = omd_pkg::TGT_FLASH; // see R1
    end else if (in_range(a, `OMD_FLASH_B5_END + 24'h000001, `OMD_FLASH_RSV_END)) begin
      // Left on the flash; software must not map here
      nxt_route.target = omd_pkg::TGT_FLASH; // see R3
    end else if (in_range(a, `OMD_XRAM_LO_BASE, `OMD_XRAM_LO_END)) begin
      if (vis_en_ff[`OMD_EN_XRAM_LO]) begin
        nxt_route.target = omd_pkg::TGT_XRAM_LO; // see R5
      end else begin
        nxt_route.target = omd_pkg::TGT_EXTERNAL; // see R6
      end
    end else if (a[23:16] == win3_seg_ff) begin
      if (vis_en_ff[`OMD_EN_XRAM_HI]) begin
        nxt_route.target = omd_pkg::TGT_XRAM_HI; // see R7
        nxt_route.addr = a & `OMD_XRAM_HI_MASK; // see R8
      end
    end else if (in_page(a, `OMD_CAN1_PAGE)) begin
      if (vis_en_ff[`OMD_EN_CAN1]) begin
        nxt_route.target = omd_pkg::TGT_CAN1; // see R10
      end
    end else if (in_page(a, `OMD_CAN2_PAGE)) begin
      if (vis_en_ff[`OMD_EN_CAN2]) begin
        nxt_route.target = omd_pkg::TGT_CAN2; // see R11
      end
    end else if (in_page(a, `OMD_RTC_PAGE)) begin
      if (vis_en_ff[`OMD_EN_RTC]) begin
        nxt_route.target = omd_pkg::TGT_RTC; // see R12
      end
    end else if (in_page(a, `OMD_PWM_PAGE)) begin
      if (vis_en_ff[`OMD_EN_PWM]) begin
        nxt_route.target = omd_pkg::TGT_PWM; // see R13
      end
    end else if (in_page(a, `OMD_ASC_PAGE)) begin
      if (vis_en_ff[`OMD_EN_ASC]) begin
        nxt_route.target = omd_pkg::TGT_ASC; // see R14
      end
    end else if (in_page(a, `OMD_SSC_PAGE)) begin
      if (vis_en_ff[`OMD_EN_SSC]) begin
        nxt_route.target = omd_pkg::TGT_SSC; // see R15
      end
    end else if (in_page(a, `OMD_I2C_PAGE)) begin
      if (vis_en_ff[`OMD_EN_I2C]) begin
        nxt_route.target = omd_pkg::TGT_I2C; // see R16
      end
    end else if (in_page(a, `OMD_MISC_PAGE)) begin
      if (vis_en_ff[`OMD_EN_MISC]) begin
        nxt_route.target = omd_pkg::TGT_MISC; // see R17
      end
    end else if (in_range(a, `OMD_EXTENDED_SPECIAL_REGS_BASE, `OMD_EXTENDED_SPECIAL_REGS_END)) begin
      nxt_route.target = omd_pkg::TGT_EXTENDED_SPECIAL_REGS; // see R22
    end else if (in_range(a, `OMD_INTERNAL_DUAL_PORT_RAM_BASE, `OMD_INTERNAL_DUAL_PORT_RAM_END)) begin
      nxt_route.target = omd_pkg::TGT_INTERNAL_DUAL_PORT_RAM;
    end else if (in_range(a, `OMD_SFR_BASE, `OMD_SFR_END)) begin
      nxt_route.target = omd_pkg::TGT_SFR; // see R22
    end
    // Peripherals: two waits, word path only
    if (is_periph(nxt_route.target)) begin
      nxt_route.waits = `OMD_PERIPH_WAITS; // see R18
      nxt_route.word_only = 1'b1; // see R13
      nxt_route.size_error = !req_in.is_word; // see R18
    end else begin
      // Memories and external take bytes and words, no waits here
      nxt_route.waits = 2'h0; // see R4
      nxt_route.word_only = 1'b0; // see R21
      nxt_route.size_error = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Access sequencing

  // New access accepted only while idle
  assign req_ready_out = (state_ff == ST_IDLE);

  assign take = req_valid_in && (state_ff == ST_IDLE);

  always_comb begin
    nxt_state = state_ff;
    nxt_wait_cnt = wait_cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_wait_cnt = nxt_route.waits;
          if (nxt_route.waits != 2'h0) begin
            nxt_state = ST_WAIT;
          end else begin
            nxt_state = ST_DONE;
          end
        end
      end
      ST_WAIT: begin
        nxt_wait_cnt = wait_cnt_ff - 2'h1;
        if (wait_cnt_ff == 2'h1) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state_ff <= ST_IDLE;
      wait_cnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      wait_cnt_ff <= nxt_wait_cnt;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      route_ff <= '0;
    end else if (take) begin
      route_ff <= nxt_route;
    end
  end

  assign route_out = route_ff;
  assign route_valid_out = (state_ff == ST_DONE);

endmodule

// ===== verilog/omd_pkg.sv
// Types shared by the memory map decoder
package omd_pkg;

  typedef enum logic [4:0] {
    TGT_FLASH,
    TGT_TEST_FLASH,
    TGT_INTERNAL_DUAL_PORT_RAM,
    TGT_SFR,
    TGT_EXTENDED_SPECIAL_REGS,
    TGT_XRAM_LO,
    TGT_XRAM_HI,
    TGT_CAN1,
    TGT_CAN2,
    TGT_RTC,
    TGT_PWM,
    TGT_ASC,
    TGT_SSC,
    TGT_I2C,
    TGT_MISC,
    TGT_EXTERNAL
  } omd_target_t;

  typedef struct packed {
    logic [23:0] addr;
    logic is_word;
    logic is_write;
  } omd_req_t;

  typedef struct packed {
    omd_target_t target;
    logic [23:0] addr;
    logic [1:0] waits;
    logic word_only;
    logic size_error;
  } omd_route_t;

endpackage
